// [cit_pkg.sv]
// package of timing constants and encodings for the instruction timing model
`default_nettype none
package cit_pkg;
   localparam int CLK_PERIOD_NS = 4;
   // operation classes
   typedef enum logic [4:0] {
      CIT_OP_SHIFT1     = 5'h00,
      CIT_OP_SHIFTCNT   = 5'h01,
      CIT_OP_ALU        = 5'h02,
      CIT_OP_REPEAT     = 5'h03,
      CIT_OP_RETURN     = 5'h04,
      CIT_OP_STEP_TRAP  = 5'h05,
      CIT_OP_SEGMENT    = 5'h06,
      CIT_OP_SCAN       = 5'h07,
      CIT_OP_STORE      = 5'h08,
      CIT_OP_EXCHANGE   = 5'h09,
      CIT_OP_TRANSLATE  = 5'h0a,
      CIT_OP_SETFLAG    = 5'h0b
   } cit_op_e;
   // operand forms
   typedef enum logic [2:0] {
      CIT_FORM_REG_REG  = 3'h0,
      CIT_FORM_REG_MEM  = 3'h1,
      CIT_FORM_MEM_REG  = 3'h2,
      CIT_FORM_ACC_IMM  = 3'h3,
      CIT_FORM_REG_IMM  = 3'h4,
      CIT_FORM_MEM_IMM  = 3'h5,
      CIT_FORM_ACC_REG  = 3'h6
   } cit_form_e;
   localparam logic [7:0] CIT_SHIFT1_REG       = 8'h02;
   localparam logic [7:0] CIT_SHIFT1_MEM       = 8'h0f;
   localparam logic [7:0] CIT_SHIFTCNT_REG     = 8'h08;
   localparam logic [7:0] CIT_SHIFTCNT_MEM     = 8'h14;
   localparam logic [7:0] CIT_PER_BIT          = 8'h04;
   localparam logic [7:0] CIT_ALU_RR           = 8'h03;
   localparam logic [7:0] CIT_ALU_RM           = 8'h09;
   localparam logic [7:0] CIT_ALU_MR           = 8'h10;
   localparam logic [7:0] CIT_ALU_IMM          = 8'h04;
   localparam logic [7:0] CIT_ALU_MI           = 8'h11;
   localparam logic [7:0] CIT_PREFIX           = 8'h02;
   localparam logic [7:0] CIT_RET_NEAR         = 8'h08;
   localparam logic [7:0] CIT_RET_NEAR_ADJ     = 8'h0c;
   localparam logic [7:0] CIT_RET_FAR          = 8'h12;
   localparam logic [7:0] CIT_RET_FAR_ADJ      = 8'h11;
   localparam logic [7:0] CIT_STEP_TRAP        = 8'h32;
   localparam logic [3:0] CIT_STEP_XFERS       = 4'h5;
   localparam logic [7:0] CIT_SCAN_ONCE        = 8'h0f;
   localparam logic [7:0] CIT_STORE_ONCE       = 8'h0b;
   localparam logic [7:0] CIT_REP_BASE         = 8'h09;
   localparam logic [7:0] CIT_SCAN_PER_REP     = 8'h0f;
   localparam logic [7:0] CIT_STORE_PER_REP    = 8'h0a;
   localparam logic [7:0] CIT_EXCHANGE_OP_ACC         = 8'h03;
   localparam logic [7:0] CIT_EXCHANGE_OP_RR          = 8'h04;
   localparam logic [7:0] CIT_EXCHANGE_OP_MEM         = 8'h11;
   localparam logic [7:0] CIT_TRANSLATE        = 8'h0b;
   localparam logic [7:0] CIT_SETFLAG          = 8'h02;
   localparam logic [7:0] CIT_WORD_PENALTY     = 8'h04;
   localparam int         CIT_SEG_SHIFT        = 4;
endpackage : cit_pkg
`default_nettype wire

// [cit_base_rom.sv]
// base clock and transfer table per operation class and operand form
`timescale 1ns/1ps
`default_nettype none
module cit_base_rom
(
   // lookup key
   input  wire logic [4:0]  op,
   input  wire logic [2:0]  form,
   input  wire logic        far_ret,
   input  wire logic        adjust,
   input  wire logic        repeated,
   // lookup result
   output logic      [7:0]  base_clocks,
   output logic      [7:0]  per_unit,
   output logic      [3:0]  xfers,
   output logic             xfer_per_unit,
   output logic             mem_operand,
   output logic             imm_operand
);
   always_comb
   begin
      base_clocks   = 8'h00;
      per_unit      = 8'h00;
      xfers         = 4'h0;
      xfer_per_unit = 1'b0;
      mem_operand   = 1'b0;
      imm_operand   = 1'b0;
      case (op)
         cit_pkg::CIT_OP_SHIFT1:
         begin
            mem_operand = (form != cit_pkg::CIT_FORM_REG_REG);
            base_clocks = mem_operand ? cit_pkg::CIT_SHIFT1_MEM : cit_pkg::CIT_SHIFT1_REG;
            xfers       = mem_operand ? 4'h2 : 4'h0;
         end
         cit_pkg::CIT_OP_SHIFTCNT:
         begin
            mem_operand = (form != cit_pkg::CIT_FORM_REG_REG);
            base_clocks = mem_operand ? cit_pkg::CIT_SHIFTCNT_MEM : cit_pkg::CIT_SHIFTCNT_REG;
            per_unit    = cit_pkg::CIT_PER_BIT;
            xfers       = mem_operand ? 4'h2 : 4'h0;
         end
         cit_pkg::CIT_OP_ALU, cit_pkg::CIT_OP_EXCHANGE:
         begin
            case (form)
               cit_pkg::CIT_FORM_REG_REG:
               begin
                  base_clocks = (op == cit_pkg::CIT_OP_ALU) ? cit_pkg::CIT_ALU_RR : cit_pkg::CIT_EXCHANGE_OP_RR;
               end
               cit_pkg::CIT_FORM_REG_MEM:
               begin
                  mem_operand = 1'b1;
                  base_clocks = (op == cit_pkg::CIT_OP_ALU) ? cit_pkg::CIT_ALU_RM : cit_pkg::CIT_EXCHANGE_OP_MEM;
                  xfers       = (op == cit_pkg::CIT_OP_ALU) ? 4'h1 : 4'h2;
               end
               cit_pkg::CIT_FORM_MEM_REG:
               begin
                  mem_operand = 1'b1;
                  base_clocks = (op == cit_pkg::CIT_OP_ALU) ? cit_pkg::CIT_ALU_MR : cit_pkg::CIT_EXCHANGE_OP_MEM;
                  xfers       = 4'h2;
               end
               cit_pkg::CIT_FORM_ACC_IMM, cit_pkg::CIT_FORM_REG_IMM:
               begin
                  imm_operand = (op == cit_pkg::CIT_OP_ALU);
                  base_clocks = (op == cit_pkg::CIT_OP_ALU) ? cit_pkg::CIT_ALU_IMM : cit_pkg::CIT_EXCHANGE_OP_RR;
               end
               cit_pkg::CIT_FORM_MEM_IMM:
               begin
                  mem_operand = 1'b1;
                  imm_operand = (op == cit_pkg::CIT_OP_ALU);
                  base_clocks = (op == cit_pkg::CIT_OP_ALU) ? cit_pkg::CIT_ALU_MI : cit_pkg::CIT_EXCHANGE_OP_MEM;
                  xfers       = 4'h2;
               end
               cit_pkg::CIT_FORM_ACC_REG:
               begin
                  base_clocks = (op == cit_pkg::CIT_OP_ALU) ? cit_pkg::CIT_ALU_RR : cit_pkg::CIT_EXCHANGE_OP_ACC;
               end
               default:
               begin
                  base_clocks = cit_pkg::CIT_ALU_RR;
               end
            endcase
         end
         cit_pkg::CIT_OP_REPEAT, cit_pkg::CIT_OP_SEGMENT:
         begin
            base_clocks = cit_pkg::CIT_PREFIX;
         end
         cit_pkg::CIT_OP_RETURN:
         begin
            if (far_ret)
               base_clocks = adjust ? cit_pkg::CIT_RET_FAR_ADJ : cit_pkg::CIT_RET_FAR;
            else
               base_clocks = adjust ? cit_pkg::CIT_RET_NEAR_ADJ : cit_pkg::CIT_RET_NEAR;
            xfers = far_ret ? 4'h2 : 4'h1;
         end
         cit_pkg::CIT_OP_STEP_TRAP:
         begin
            base_clocks = cit_pkg::CIT_STEP_TRAP;
            xfers       = cit_pkg::CIT_STEP_XFERS;
         end
         cit_pkg::CIT_OP_SCAN:
         begin
            base_clocks   = repeated ? cit_pkg::CIT_REP_BASE : cit_pkg::CIT_SCAN_ONCE;
            per_unit      = repeated ? cit_pkg::CIT_SCAN_PER_REP : 8'h00;
            xfers         = repeated ? 4'h0 : 4'h1;
            xfer_per_unit = repeated;
         end
         cit_pkg::CIT_OP_STORE:
         begin
            base_clocks   = repeated ? cit_pkg::CIT_REP_BASE : cit_pkg::CIT_STORE_ONCE;
            per_unit      = repeated ? cit_pkg::CIT_STORE_PER_REP : 8'h00;
            xfers         = repeated ? 4'h0 : 4'h1;
            xfer_per_unit = repeated;
         end
         cit_pkg::CIT_OP_TRANSLATE:
         begin
            base_clocks = cit_pkg::CIT_TRANSLATE;
            xfers       = 4'h1;
            mem_operand = 1'b1;
         end
         cit_pkg::CIT_OP_SETFLAG:
         begin
            base_clocks = cit_pkg::CIT_SETFLAG;
         end
         default:
         begin
            base_clocks = 8'h00;
         end
      endcase
   end
endmodule : cit_base_rom
`default_nettype wire

// [cit_addr_gen.sv]
// physical address former: shifted segment plus effective address
`timescale 1ns/1ps
`default_nettype none
module cit_addr_gen
(
   // operands
   input  wire logic [15:0] segment,
   input  wire logic [15:0] eff_addr,
   // result
   output logic      [19:0] phys_addr
);
   // unsigned 16-bit offset, wraps inside 20 bits
   assign phys_addr = {segment, 4'h0} + {4'h0, eff_addr};
endmodule : cit_addr_gen
`default_nettype wire

// [cit_timing.sv]
// instruction timing model: totals clocks and counts bus transfers per instruction
// Contract
// - wide-bus variant adds four clocks per odd-addressed word transfer
// - narrow-bus variant adds four clocks per word transfer, any alignment
// - register-only instructions run internally and start no bus cycle
// - immediate operands are eight or sixteen bits wide
// - immediates come from the instruction queue without a bus cycle
// - an immediate may only be a source, never a destination
// - counted shift: 8 plus 4 per bit, memory 20 plus address plus 4 per bit
// - subtract and xor: 3, 9, 16, 4, 17 clocks by operand form
// - each repeat prefix is one byte costing 2 clocks
// - return costs 8, 12, 18 or 17 clocks by form
// - single-step trap costs 50 clocks and 5 transfers
// - segment override prefix is one byte costing 2 clocks
// - scan string 15 once, or 9 plus 15 per repetition
// - store string 11 once, or 9 plus 10 per repetition
// - translate is one byte, 11 clocks, one transfer
// - set carry, direction, interrupt flag: one byte, 2 clocks, no transfer
// - effective address is an unsigned 16-bit offset into the segment
// - physical address is shifted segment plus offset, 20 bits wide
`timescale 1ns/1ps
`default_nettype none
module cit_timing
#(
   parameter bit NARROW_BUS = 1'b0
)
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // instruction request
   input  wire logic        req_valid,
   input  wire logic [4:0]  req_op,
   input  wire logic [2:0]  req_form,
   input  wire logic        req_far,
   input  wire logic        req_adjust,
   input  wire logic        req_word,
   input  wire logic        req_imm16,
   input  wire logic [7:0]  req_prefix_count,
   input  wire logic        req_repeated,
   input  wire logic [7:0]  req_units,
   input  wire logic [7:0]  req_ea_clocks,
   input  wire logic [15:0] req_eff_addr,
   input  wire logic [15:0] req_segment,
   input  wire logic        req_imm_dest,
   // result
   output logic             res_valid,
   output logic [15:0]      res_clocks,
   output logic [11:0]      res_xfers,
   output logic [19:0]      res_phys_addr,
   output logic             res_bus_used,
   output logic [4:0]       res_imm_bytes,
   output logic             res_illegal
);
   logic [7:0]  base_clocks;
   logic [7:0]  per_unit;
   logic [3:0]  xfers;
   logic        xfer_per_unit;
   logic        mem_operand;
   logic        imm_operand;
   logic [19:0] phys_addr;
   logic [11:0] next_xfers;
   logic [15:0] next_clocks;
   logic [15:0] penalty;
   logic        penalised;
   logic        next_illegal;

   cit_base_rom cit_base_rom_inst
   (
      .op            (req_op),
      .form          (req_form),
      .far_ret       (req_far),
      .adjust        (req_adjust),
      .repeated      (req_repeated),
      .base_clocks   (base_clocks),
      .per_unit      (per_unit),
      .xfers         (xfers),
      .xfer_per_unit (xfer_per_unit),
      .mem_operand   (mem_operand),
      .imm_operand   (imm_operand)
   );

   cit_addr_gen cit_addr_gen_inst
   (
      .segment   (req_segment),
      .eff_addr  (req_eff_addr),
      .phys_addr (phys_addr)
   );

   always_comb
   begin
      next_xfers = xfer_per_unit ? {4'h0, req_units} : {8'h00, xfers};
      // word penalty: narrow bus always, wide bus only on odd address
      penalised = req_word && (NARROW_BUS || req_eff_addr[0]);
      penalty = penalised ? (16'(cit_pkg::CIT_WORD_PENALTY) * 16'(next_xfers)) : 16'h0000;
      next_clocks = 16'(req_prefix_count) * 16'(cit_pkg::CIT_PREFIX)
                  + 16'(base_clocks)
                  + (mem_operand ? 16'(req_ea_clocks) : 16'h0000)
                  + 16'(per_unit) * 16'(req_units)
                  + penalty;
      // immediate as destination has no encoding
      next_illegal = req_imm_dest;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         res_valid <= 1'b0;
      else
         res_valid <= req_valid;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         res_clocks    <= 16'h0000;
         res_xfers     <= 12'h000;
         res_phys_addr <= 20'h00000;
         res_bus_used  <= 1'b0;
         res_imm_bytes <= 5'h00;
         res_illegal   <= 1'b0;
      end
      else if (req_valid)
      begin
         res_clocks    <= next_clocks;
         res_xfers     <= next_xfers;
         // register and immediate operands never reach the bus
         res_phys_addr <= mem_operand ? phys_addr : 20'h00000;
         res_bus_used  <= (next_xfers != 12'h000);
         res_imm_bytes <= imm_operand ? (req_imm16 ? 5'h02 : 5'h01) : 5'h00;
         res_illegal   <= next_illegal;
      end
   end

   property p_reg_no_bus;
      @(posedge ref_clk) disable iff (rst)
      (req_valid && req_op == 5'(cit_pkg::CIT_OP_ALU) && req_form == 3'(cit_pkg::CIT_FORM_REG_REG))
      |=> !res_bus_used && res_xfers == 12'h000;
   endproperty
   a_reg_no_bus: assert property (p_reg_no_bus) else $error("register form used bus");

   property p_shift1_reg;
      @(posedge ref_clk) disable iff (rst)
      (req_valid && req_op == 5'(cit_pkg::CIT_OP_SHIFT1) && req_form == 3'(cit_pkg::CIT_FORM_REG_REG)
       && req_prefix_count == 8'h00 && req_units == 8'h00)
      |=> res_clocks == 16'h0002;
   endproperty
   a_shift1_reg: assert property (p_shift1_reg) else $error("single shift not 2 clocks");

   property p_shiftcnt_reg;
      @(posedge ref_clk) disable iff (rst)
      (req_valid && req_op == 5'(cit_pkg::CIT_OP_SHIFTCNT) && req_form == 3'(cit_pkg::CIT_FORM_REG_REG)
       && req_prefix_count == 8'h00 && req_units == 8'h03)
      |=> res_clocks == 16'h0014;
   endproperty
   a_shiftcnt_reg: assert property (p_shiftcnt_reg) else $error("counted shift wrong");

   property p_trap;
      @(posedge ref_clk) disable iff (rst)
      (req_valid && req_op == 5'(cit_pkg::CIT_OP_STEP_TRAP) && req_prefix_count == 8'h00
       && !req_word && req_units == 8'h00)
      |=> res_clocks == 16'h0032 && res_xfers == 12'h005;
   endproperty
   a_trap: assert property (p_trap) else $error("trap cost wrong");

   property p_scan_rep;
      @(posedge ref_clk) disable iff (rst)
      (req_valid && req_op == 5'(cit_pkg::CIT_OP_SCAN) && req_repeated && req_prefix_count == 8'h00
       && !req_word && req_units == 8'h02)
      |=> res_clocks == 16'h0027 && res_xfers == 12'h002;
   endproperty
   a_scan_rep: assert property (p_scan_rep) else $error("repeated scan wrong");

   property p_narrow_penalty;
      @(posedge ref_clk) disable iff (rst)
      (req_valid && req_op == 5'(cit_pkg::CIT_OP_TRANSLATE) && req_word && req_prefix_count == 8'h00
       && req_units == 8'h00 && req_ea_clocks == 8'h00 && (NARROW_BUS || req_eff_addr[0]))
      |=> res_clocks == 16'h000f;
   endproperty
   a_narrow_penalty: assert property (p_narrow_penalty) else $error("word penalty missing");

   property p_even_no_penalty;
      @(posedge ref_clk) disable iff (rst)
      (req_valid && !NARROW_BUS && req_op == 5'(cit_pkg::CIT_OP_TRANSLATE) && req_word
       && !req_eff_addr[0] && req_prefix_count == 8'h00 && req_units == 8'h00 && req_ea_clocks == 8'h00)
      |=> res_clocks == 16'h000b;
   endproperty
   a_even_no_penalty: assert property (p_even_no_penalty) else $error("even word penalised");

   property p_prefix_sum;
      @(posedge ref_clk) disable iff (rst)
      (req_valid && req_op == 5'(cit_pkg::CIT_OP_SETFLAG) && req_prefix_count == 8'h02 && req_units == 8'h00)
      |=> res_clocks == 16'h0006 && !res_bus_used;
   endproperty
   a_prefix_sum: assert property (p_prefix_sum) else $error("prefix total wrong");

   property p_phys;
      @(posedge ref_clk) disable iff (rst)
      (req_valid && req_op == 5'(cit_pkg::CIT_OP_TRANSLATE))
      |=> res_phys_addr == ($past(req_segment) * 20'h00010 + 20'($past(req_eff_addr)));
   endproperty
   a_phys: assert property (p_phys) else $error("physical address wrong");

   property p_valid_follows;
      @(posedge ref_clk) disable iff (rst)
      req_valid |=> res_valid;
   endproperty
   a_valid_follows: assert property (p_valid_follows) else $error("result not one cycle later");

   c_ret_far: cover property (@(posedge ref_clk) disable iff (rst)
      req_valid && req_op == 5'(cit_pkg::CIT_OP_RETURN) && req_far);
   c_store_rep: cover property (@(posedge ref_clk) disable iff (rst)
      req_valid && req_op == 5'(cit_pkg::CIT_OP_STORE) && req_repeated);
   c_exchange_op_mem: cover property (@(posedge ref_clk) disable iff (rst)
      req_valid && req_op == 5'(cit_pkg::CIT_OP_EXCHANGE) && req_form == 3'(cit_pkg::CIT_FORM_MEM_REG));
endmodule : cit_timing
`default_nettype wire

// [cit_bus_partner.sv]
// system bus partner: memory and I/O side that tallies the transfers each instruction asks of it
`timescale 1ns/1ps
`default_nettype none
module cit_bus_partner
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // transfer demand from the timing model
   input  wire logic        res_valid,
   input  wire logic        res_bus_used,
   input  wire logic [11:0] res_xfers,
   // service tally
   output logic      [31:0] served,
   output logic      [31:0] stray
);
   // only answers when a bus cycle was really started
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         served <= 32'h0;
      else if (res_valid && res_bus_used)
         served <= served + 32'(res_xfers);
   end

   // transfers claimed without the bus being used would never be served
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         stray <= 32'h0;
      else if (res_valid && !res_bus_used && res_xfers != 12'h0)
         stray <= stray + 32'h1;
   end
endmodule : cit_bus_partner
`default_nettype wire

// [cit_timing_bench.sv]
// self-checking bench for the instruction timing model, wide and narrow bus variants
`timescale 1ns/1ps
`default_nettype none
module cit_timing_bench;
   typedef struct {
      logic [4:0]  op;    logic [2:0] form; logic fa; logic ad; logic wd;
      logic [7:0]  pfx;   logic rep;  logic [7:0] units; logic [7:0] ea;
      logic [15:0] eff;   logic idest; logic [4:0] imm;
      logic [15:0] clk;   logic [11:0] xf; logic [1:0] amode;
   } cit_row_s;
   logic        ref_clk, rst, req_valid, req_far, req_adjust, req_word, req_imm16;
   logic        req_repeated, req_imm_dest;
   logic [4:0]  req_op;
   logic [2:0]  req_form;
   logic [7:0]  req_prefix_count, req_units, req_ea_clocks;
   logic [15:0] req_eff_addr, req_segment;
   logic        w_valid, w_bus, w_ill, n_valid, n_bus, n_ill;
   logic [15:0] w_clocks, n_clocks;
   logic [11:0] w_xfers, n_xfers;
   logic [19:0] w_phys, n_phys;
   logic [4:0]  w_imm, n_imm;
   logic [31:0] served, stray, total_xf;
   cit_row_s    rows[$];
   integer      failures, comparisons, cycles;

   cit_timing #(.NARROW_BUS(1'b0)) cit_timing_inst (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid),
      .req_op(req_op), .req_form(req_form), .req_far(req_far), .req_adjust(req_adjust), .req_word(req_word),
      .req_imm16(req_imm16), .req_prefix_count(req_prefix_count), .req_repeated(req_repeated),
      .req_units(req_units), .req_ea_clocks(req_ea_clocks), .req_eff_addr(req_eff_addr),
      .req_segment(req_segment), .req_imm_dest(req_imm_dest), .res_valid(w_valid), .res_clocks(w_clocks),
      .res_xfers(w_xfers), .res_phys_addr(w_phys), .res_bus_used(w_bus), .res_imm_bytes(w_imm),
      .res_illegal(w_ill));
   // second instance covers the narrow-bus penalty on the same stimulus
   cit_timing #(.NARROW_BUS(1'b1)) cit_timing_narrow_inst (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid),
      .req_op(req_op), .req_form(req_form), .req_far(req_far), .req_adjust(req_adjust), .req_word(req_word),
      .req_imm16(req_imm16), .req_prefix_count(req_prefix_count), .req_repeated(req_repeated),
      .req_units(req_units), .req_ea_clocks(req_ea_clocks), .req_eff_addr(req_eff_addr),
      .req_segment(req_segment), .req_imm_dest(req_imm_dest), .res_valid(n_valid), .res_clocks(n_clocks),
      .res_xfers(n_xfers), .res_phys_addr(n_phys), .res_bus_used(n_bus), .res_imm_bytes(n_imm),
      .res_illegal(n_ill));
   cit_bus_partner cit_bus_partner_inst (.ref_clk(ref_clk), .rst(rst), .res_valid(w_valid),
      .res_bus_used(w_bus), .res_xfers(w_xfers), .served(served), .stray(stray));

   initial
   begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   task complete_run;
      if (failures == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : complete_run

   // ceiling is well above the 41 or so cycles the tests need
   always @(posedge ref_clk)
   begin
      cycles = cycles + 1;
      if (cycles == 3000)
      begin
         failures = failures + 1;
         complete_run();
      end
   end

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp)
      begin
         failures = failures + 1;
         $display("ERROR %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : check

   task add(input logic [4:0] op, input logic [2:0] form, input logic fa, input logic ad, input logic wd,
            input logic [7:0] pfx, input logic rep, input logic [7:0] units, input logic [7:0] ea,
            input logic [15:0] eff, input logic idest, input logic [4:0] imm, input logic [15:0] clk,
            input logic [11:0] xf, input logic [1:0] amode);
      rows.push_back('{op, form, fa, ad, wd, pfx, rep, units, ea, eff, idest, imm, clk, xf, amode});
      total_xf = total_xf + 32'(xf);
   endtask : add

   task drive(input int i);
      req_valid        = 1'b1;
      req_op           = rows[i].op;
      req_form         = rows[i].form;
      req_far          = rows[i].fa;
      req_adjust       = rows[i].ad;
      req_word         = rows[i].wd;
      req_imm16        = (rows[i].imm == 5'h02);
      req_prefix_count = rows[i].pfx;
      req_repeated     = rows[i].rep;
      req_units        = rows[i].units;
      req_ea_clocks    = rows[i].ea;
      req_eff_addr     = rows[i].eff;
      req_segment      = 16'h1200 + 16'(i);
      req_imm_dest     = rows[i].idest;
   endtask : drive

   task check_row(input int i);
      cit_row_s    r;
      logic [15:0] pen;
      logic [19:0] pa;
      r   = rows[i];
      pen = 16'(r.xf) * 16'h0004;
      pa  = {16'h1200 + 16'(i), 4'h0} + {4'h0, r.eff};
      check("wide valid", w_valid, 1);
      check("narrow valid", n_valid, 1);
      check("wide clocks", w_clocks, r.clk + ((r.wd && r.eff[0]) ? pen : 16'h0));
      check("narrow clocks", n_clocks, r.clk + (r.wd ? pen : 16'h0));
      check("xfers", w_xfers, r.xf);
      check("bus used", w_bus, r.xf != 12'h0);
      check("imm bytes", w_imm, r.imm);
      check("illegal", w_ill, r.idest);
      if (r.amode != 2'h0)
         check("phys addr", w_phys, (r.amode == 2'h2) ? pa : 20'h0);
   endtask : check_row

   initial
   begin
      failures = 0;  comparisons = 0;  cycles = 0;  total_xf = 0;
      rst = 1'b1;
      add(cit_pkg::CIT_OP_SHIFT1, cit_pkg::CIT_FORM_REG_REG, 0, 0, 1, 0, 0, 0, 0, 16'h0003, 0, 0, 2, 0, 1);
      add(cit_pkg::CIT_OP_SHIFT1, cit_pkg::CIT_FORM_MEM_REG, 0, 0, 1, 0, 0, 0, 7, 16'hffff, 0, 0, 22, 2, 2);
      add(cit_pkg::CIT_OP_SHIFTCNT, cit_pkg::CIT_FORM_REG_REG, 0, 0, 0, 0, 0, 3, 0, 16'h0, 0, 0, 20, 0, 1);
      add(cit_pkg::CIT_OP_SHIFTCNT, cit_pkg::CIT_FORM_REG_MEM, 0, 0, 0, 0, 0, 0, 5, 16'h8000, 0, 0, 25, 2, 2);
      add(cit_pkg::CIT_OP_ALU, cit_pkg::CIT_FORM_REG_REG, 0, 0, 1, 2, 0, 0, 0, 16'h0001, 0, 0, 7, 0, 1);
      add(cit_pkg::CIT_OP_ALU, cit_pkg::CIT_FORM_REG_MEM, 0, 0, 1, 0, 0, 0, 6, 16'h0010, 0, 0, 15, 1, 2);
      add(cit_pkg::CIT_OP_ALU, cit_pkg::CIT_FORM_MEM_REG, 0, 0, 1, 0, 0, 0, 6, 16'h0011, 0, 0, 22, 2, 2);
      add(cit_pkg::CIT_OP_ALU, cit_pkg::CIT_FORM_ACC_IMM, 0, 0, 0, 0, 0, 0, 0, 16'h0, 0, 1, 4, 0, 1);
      add(cit_pkg::CIT_OP_ALU, cit_pkg::CIT_FORM_REG_IMM, 0, 0, 0, 0, 0, 0, 0, 16'h0, 0, 2, 4, 0, 1);
      add(cit_pkg::CIT_OP_ALU, cit_pkg::CIT_FORM_MEM_IMM, 0, 0, 0, 0, 0, 0, 9, 16'h0002, 0, 1, 26, 2, 2);
      add(cit_pkg::CIT_OP_ALU, cit_pkg::CIT_FORM_REG_IMM, 0, 0, 0, 0, 0, 0, 0, 16'h0, 1, 2, 4, 0, 1);
      add(cit_pkg::CIT_OP_REPEAT, cit_pkg::CIT_FORM_REG_REG, 0, 0, 0, 0, 0, 0, 0, 16'h0, 0, 0, 2, 0, 0);
      add(cit_pkg::CIT_OP_SEGMENT, cit_pkg::CIT_FORM_REG_REG, 0, 0, 0, 0, 0, 0, 0, 16'h0, 0, 0, 2, 0, 0);
      add(cit_pkg::CIT_OP_RETURN, cit_pkg::CIT_FORM_REG_REG, 0, 0, 0, 0, 0, 0, 0, 16'h0, 0, 0, 8, 1, 0);
      add(cit_pkg::CIT_OP_RETURN, cit_pkg::CIT_FORM_REG_REG, 0, 1, 0, 0, 0, 0, 0, 16'h0, 0, 0, 12, 1, 0);
      add(cit_pkg::CIT_OP_RETURN, cit_pkg::CIT_FORM_REG_REG, 1, 0, 0, 0, 0, 0, 0, 16'h0, 0, 0, 18, 2, 0);
      add(cit_pkg::CIT_OP_RETURN, cit_pkg::CIT_FORM_REG_REG, 1, 1, 0, 0, 0, 0, 0, 16'h0, 0, 0, 17, 2, 0);
      add(cit_pkg::CIT_OP_STEP_TRAP, cit_pkg::CIT_FORM_REG_REG, 0, 0, 0, 0, 0, 0, 0, 16'h0, 0, 0, 50, 5, 0);
      add(cit_pkg::CIT_OP_SCAN, cit_pkg::CIT_FORM_REG_REG, 0, 0, 0, 0, 0, 0, 0, 16'h0, 0, 0, 15, 1, 0);
      add(cit_pkg::CIT_OP_SCAN, cit_pkg::CIT_FORM_REG_REG, 0, 0, 0, 0, 1, 2, 0, 16'h0, 0, 0, 39, 2, 0);
      add(cit_pkg::CIT_OP_STORE, cit_pkg::CIT_FORM_REG_REG, 0, 0, 0, 0, 0, 0, 0, 16'h0, 0, 0, 11, 1, 0);
      add(cit_pkg::CIT_OP_STORE, cit_pkg::CIT_FORM_REG_REG, 0, 0, 0, 1, 1, 3, 0, 16'h0, 0, 0, 41, 3, 0);
      add(cit_pkg::CIT_OP_EXCHANGE, cit_pkg::CIT_FORM_ACC_REG, 0, 0, 0, 0, 0, 0, 0, 16'h0, 0, 0, 3, 0, 1);
      add(cit_pkg::CIT_OP_EXCHANGE, cit_pkg::CIT_FORM_REG_REG, 0, 0, 0, 0, 0, 0, 0, 16'h0, 0, 0, 4, 0, 1);
      add(cit_pkg::CIT_OP_EXCHANGE, cit_pkg::CIT_FORM_MEM_REG, 0, 0, 0, 0, 0, 0, 8, 16'h40, 0, 0, 25, 2, 2);
      add(cit_pkg::CIT_OP_TRANSLATE, cit_pkg::CIT_FORM_REG_REG, 0, 0, 1, 0, 0, 0, 0, 16'h0, 0, 0, 11, 1, 2);
      add(cit_pkg::CIT_OP_SETFLAG, cit_pkg::CIT_FORM_REG_REG, 0, 0, 0, 2, 0, 0, 0, 16'h0, 0, 0, 6, 0, 1);
      // inputs take defined values from the table before reset is released
      drive(0);
      repeat (8) @(posedge ref_clk);
      #1;
      req_valid = 1'b0;
      check("reset valid", w_valid, 0);
      check("reset clocks", w_clocks, 0);
      rst = 1'b0;
      // back to back: row i is driven while row i-1 is checked
      for (int i = 0; i <= rows.size(); i++)
      begin
         @(posedge ref_clk);
         #1;
         if (i > 0)
            check_row(i - 1);
         if (i < rows.size())
            drive(i);
         else
            req_valid = 1'b0;
      end
      @(posedge ref_clk);
      #1;
      check("valid drops", w_valid, 0);
      check("clocks held", w_clocks, 16'h0006);
      check("served xfers", served, total_xf);
      check("stray xfers", stray, 0);
      // reset in mid-run clears a pending memory result at once
      drive(1);
      @(posedge ref_clk);
      #1;
      req_valid = 1'b0;
      rst = 1'b1;
      #1;
      check("mid reset valid", w_valid, 0);
      check("mid reset phys", w_phys, 0);
      check("mid reset xfers", n_xfers, 0);
      repeat (2) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      drive(0);
      @(posedge ref_clk);
      #1;
      req_valid = 1'b0;
      check_row(0);
      complete_run();
   end
endmodule : cit_timing_bench
`default_nettype wire
